// ---- rtl/raster_boolean_transfer.sv ----
// pixel-serial raster boolean transfer datapath with write-back fifo
`include "rbt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// write-back fifo
// ****************************************
module rbt_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = `RBT_FIFO_DEPTH
) (
  input wire logic core_clk, // clock
  input wire logic rst, // async reset
  input wire logic in_valid, // push request
  output logic in_ready, // not full
  input wire logic [WIDTH-1:0] in_data, // push word
  output logic out_valid, // not empty
  input wire logic out_ready, // pop request
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff;
  logic [AW:0] cnt_ff;
  logic push, pop;
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_ff[rp_ff];
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ****************************************
// transfer engine
// ****************************************
module raster_boolean_transfer #(
  parameter int DEPTH = `RBT_FIFO_DEPTH
) (
  input wire logic core_clk, // 40 MHz clock
  input wire logic rst, // async reset, graphics soft reset
  input wire logic ord_valid, // order offered
  output logic ord_ready, // engine idle
  input wire rbt_pkg::order_type ord, // order parameters
  output logic rd_valid, // bit read request
  input wire logic rd_ready, // read taken
  output logic [31:0] rd_addr, // bit address to read
  input wire logic rd_resp_valid, // read data strobe
  input wire logic rd_resp_data, // read data bit
  output logic wr_valid, // bit write request
  input wire logic wr_ready, // write taken
  output logic [31:0] wr_addr, // bit address to write
  output logic wr_data, // bit to write
  output logic busy, // order in progress
  output logic done, // order finished pulse
  output logic fault, // band fault pulse
  output rbt_pkg::resume_type resume // resume state on fault
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ROW = 3'b001, S_RD = 3'b010,
    S_WT = 3'b011, S_PUSH = 3'b100, S_END = 3'b101
  } st_type;

  // the minterm of the three operand constants picks one code bit, halftone most significant
  function automatic logic rop(input logic [7:0] c, input logic h, input logic s, input logic d);
    logic [7:0] sel;
    sel = (h ? `RBT_CONST_HT : ~`RBT_CONST_HT) &
          (s ? `RBT_CONST_SRC : ~`RBT_CONST_SRC) &
          (d ? `RBT_CONST_DST : ~`RBT_CONST_DST);
    rop = |(c & sel);
  endfunction

  st_type state_ff, nxt_state;
  rbt_pkg::order_type o_ff;
  logic [15:0] row_ff, col_ff, scol_ff, hx_ff, hy_ff;
  logic [31:0] drow_ff, srow_ff, hrow_ff;
  logic [4:0] subx_ff, suby_ff;
  logic [1:0] opsel_ff, nxt_opsel;
  logic dbit_ff, sbit_ff, hbit_ff;
  logic use_s, use_h, last_col, over_band, fifo_in_ready, fifo_out_valid;
  logic [15:0] pitch;
  logic [31:0] rd_addr_ff;
  logic done_ff, fault_ff;
  rbt_pkg::resume_type resume_ff;
  rbt_pkg::wr_type push_w, head_w;

  assign use_s = (o_ff.opnd == rbt_pkg::OP_SD) || (o_ff.opnd == rbt_pkg::OP_SHD);
  assign use_h = (o_ff.opnd == rbt_pkg::OP_HD) || (o_ff.opnd == rbt_pkg::OP_SHD);
  assign pitch = (o_ff.dkind == rbt_pkg::DK_FRAME) ? o_ff.width : o_ff.warp;
  assign last_col = (col_ff == o_ff.width - 16'h0001);
  // only banded targets are bounded; unbanded and frame run to the end
  assign over_band = (o_ff.dkind == rbt_pkg::DK_BANDED) &&
                     ({1'b0, o_ff.dst_y} + {1'b0, row_ff} > {1'b0, o_ff.band_bot});

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_opsel = opsel_ff;
    unique case (state_ff)
      S_IDLE: if (ord_valid) nxt_state = S_ROW;
      S_ROW: begin
        nxt_opsel = 2'h0;
        if (row_ff >= o_ff.height || over_band) nxt_state = S_END;
        else nxt_state = S_RD;
      end
      S_RD: if (rd_ready) nxt_state = S_WT;
      S_WT: begin
        if (rd_resp_valid) begin
          // unused operands are never fetched
          if (opsel_ff == 2'h0 && use_s) begin
            nxt_opsel = 2'h1;
            nxt_state = S_RD;
          end else if (opsel_ff != 2'h2 && use_h) begin
            nxt_opsel = 2'h2;
            nxt_state = S_RD;
          end else begin
            nxt_state = S_PUSH;
          end
        end
      end
      S_PUSH: begin
        nxt_opsel = 2'h0;
        if (fifo_in_ready) nxt_state = last_col ? S_ROW : S_RD;
      end
      S_END: if (!fifo_out_valid) nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      opsel_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      opsel_ff <= nxt_opsel;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      o_ff <= '0;
    end else if (state_ff == S_IDLE && ord_valid) begin
      o_ff <= ord;
    end
  end

  // ****************************************
  // address walk
  // ****************************************
  // the source pointer is a bit address, so any bit alignment works, and the
  // replicated image exists only as the subx/suby counters, never in memory
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      row_ff <= '0;
      col_ff <= '0;
      scol_ff <= '0;
      subx_ff <= '0;
      suby_ff <= '0;
      hx_ff <= '0;
      hy_ff <= '0;
      drow_ff <= '0;
      srow_ff <= '0;
      hrow_ff <= '0;
    end else if (state_ff == S_IDLE && ord_valid) begin
      row_ff <= ord.st.row;
      col_ff <= '0;
      scol_ff <= '0;
      subx_ff <= '0;
      hx_ff <= '0;
      drow_ff <= ord.st.dst_addr;
      srow_ff <= ord.st.src_addr;
      suby_ff <= ord.st.sub_y;
      hy_ff <= ord.st.ht_y;
      hrow_ff <= ord.ht_addr + 32'(ord.st.ht_y) * 32'(ord.ht_w);
    end else if (state_ff == S_PUSH && fifo_in_ready) begin
      if (last_col) begin
        row_ff <= row_ff + 16'h0001;
        col_ff <= '0;
        scol_ff <= '0;
        subx_ff <= '0;
        hx_ff <= '0;
        drow_ff <= drow_ff + 32'(pitch);
        if (!o_ff.expand || suby_ff == o_ff.ys - 5'h01) begin
          suby_ff <= '0;
          srow_ff <= srow_ff + 32'(o_ff.src_warp);
        end else begin
          suby_ff <= suby_ff + 5'h01;
        end
        if (hy_ff == o_ff.ht_h - 16'h0001) begin
          hy_ff <= '0;
          hrow_ff <= o_ff.ht_addr;
        end else begin
          hy_ff <= hy_ff + 16'h0001;
          hrow_ff <= hrow_ff + 32'(o_ff.ht_w);
        end
      end else begin
        col_ff <= col_ff + 16'h0001;
        if (!o_ff.expand || subx_ff == o_ff.xs - 5'h01) begin
          subx_ff <= '0;
          scol_ff <= scol_ff + 16'h0001;
        end else begin
          subx_ff <= subx_ff + 5'h01;
        end
        hx_ff <= (hx_ff == o_ff.ht_w - 16'h0001) ? '0 : hx_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_addr_ff <= '0;
    end else if (state_ff == S_PUSH) begin
      // the column advances on this same edge, so aim the next read ahead of it
      rd_addr_ff <= drow_ff + 32'(col_ff) + 32'h0000_0001;
    end else begin
      unique case (nxt_opsel)
        2'h1: rd_addr_ff <= srow_ff + 32'(scol_ff);
        2'h2: rd_addr_ff <= hrow_ff + 32'(hx_ff);
        default: rd_addr_ff <= drow_ff + 32'(col_ff);
      endcase
    end
  end

  // ****************************************
  // operands and boolean unit
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dbit_ff <= 1'b0;
      sbit_ff <= 1'b0;
      hbit_ff <= 1'b0;
    end else if (state_ff == S_ROW || (state_ff == S_PUSH && fifo_in_ready)) begin
      dbit_ff <= 1'b0;
      sbit_ff <= 1'b0;
      hbit_ff <= 1'b0;
    end else if (state_ff == S_WT && rd_resp_valid) begin
      unique case (opsel_ff)
        2'h1: sbit_ff <= rd_resp_data;
        2'h2: hbit_ff <= rd_resp_data;
        default: dbit_ff <= rd_resp_data;
      endcase
    end
  end

  // the write address is the destination address just read
  assign push_w.addr = drow_ff + 32'(col_ff);
  assign push_w.data = rop(o_ff.code, hbit_ff, sbit_ff, dbit_ff);

  // limitation: a source overlapping queued destination bits may read stale data
  rbt_fifo #(.WIDTH(33), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(state_ff == S_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(push_w),
    .out_valid(fifo_out_valid),
    .out_ready(wr_ready),
    .out_data(head_w)
  );

  // ****************************************
  // status
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
      resume_ff <= '0;
    end else begin
      done_ff <= (state_ff == S_END) && !fifo_out_valid;
      fault_ff <= (state_ff == S_ROW) && (row_ff < o_ff.height) && over_band;
      if (state_ff == S_ROW && row_ff < o_ff.height && over_band) begin
        resume_ff.row <= row_ff;
        resume_ff.dst_addr <= drow_ff;
        resume_ff.src_addr <= srow_ff;
        resume_ff.sub_y <= suby_ff;
        resume_ff.ht_y <= hy_ff;
        resume_ff.band_num <= o_ff.rot180 ? o_ff.st.band_num - 8'h01 : o_ff.st.band_num + 8'h01;
      end
    end
  end

  assign ord_ready = (state_ff == S_IDLE);
  assign rd_valid = (state_ff == S_RD);
  assign rd_addr = rd_addr_ff;
  assign wr_valid = fifo_out_valid;
  assign wr_addr = head_w.addr;
  assign wr_data = head_w.data;
  assign busy = (state_ff != S_IDLE);
  assign done = done_ff;
  assign fault = fault_ff;
  assign resume = resume_ff;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_rd_taken;
    rd_valid && rd_ready && opsel_ff != 2'h0;
  endsequence
  a_no_extra_op: assert property (@(posedge core_clk) disable iff (rst)
    s_rd_taken |-> (opsel_ff == 2'h1 ? use_s : use_h)) else $error("unused operand fetched");
  a_unbanded_safe: assert property (@(posedge core_clk) disable iff (rst)
    fault |-> o_ff.dkind == rbt_pkg::DK_BANDED) else $error("fault on unbounded target");
  a_fault_ends: assert property (@(posedge core_clk) disable iff (rst)
    fault |-> state_ff == S_END) else $error("fault did not end transfer");
  a_band_step: assert property (@(posedge core_clk) disable iff (rst)
    fault |-> resume.band_num == (o_ff.rot180 ? o_ff.st.band_num - 8'h01
                                              : o_ff.st.band_num + 8'h01)) else $error("band number");
  a_scale_sub: assert property (@(posedge core_clk) disable iff (rst)
    busy && o_ff.expand |-> subx_ff < o_ff.xs && suby_ff <= 5'h0f) else $error("scale counter");
  a_frame_pitch: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == S_PUSH && fifo_in_ready && last_col && o_ff.dkind == rbt_pkg::DK_FRAME
    |=> drow_ff == $past(drow_ff) + 32'($past(o_ff.width))) else $error("frame pitch");
  a_ht_wrap: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == S_PUSH && use_h |-> hx_ff < o_ff.ht_w && hy_ff < o_ff.ht_h) else $error("halftone wrap");
  a_rop_result: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == S_PUSH |-> push_w.data == o_ff.code[{hbit_ff & use_h, sbit_ff & use_s, dbit_ff}])
    else $error("boolean result");
  a_wait_resp: assert property (@(posedge core_clk) disable iff (rst)
    rd_valid && rd_ready |=> state_ff == S_WT) else $error("read not awaited");
  a_done_drain: assert property (@(posedge core_clk) disable iff (rst)
    done |-> ord_ready ##0 !$past(fifo_out_valid)) else $error("done before drain");
endmodule
`default_nettype wire

// ---- rtl/rbt_cfg.svh ----
// constants of the raster boolean transfer datapath
// Contract
// - banded destination checked against band bottom, faults
// - unbanded destination never boundary checked
// - source may start at any bit address
// - expanded orders read unexpanded source from memory
// - replicate source pixels by factors 1 to 16
// - expansion on the fly, never stored
// - frame destination uses width as row pitch
// - frame rows packed bit contiguously
// - halftone tiles wrap horizontally and vertically
// - operand constants aa, cc, f0, 00, ff
// - all 256 boolean codes supported
// - operands not supplied read as zero
// - single operand orders touch only destination
// - two operand orders add source or halftone
// - three operand orders use all three
// - result written back into destination bitmap
// - block transfer stops past band bottom edge
// - after band fault, accept further orders
// - faulted transfer resumes from interruption point
// - fault reports resume state, band number stepped
`ifndef RBT_CFG_SVH
`define RBT_CFG_SVH
`define RBT_CONST_ZERO 8'h00
`define RBT_CONST_ONE 8'hff
`define RBT_CONST_DST 8'haa
`define RBT_CONST_SRC 8'hcc
`define RBT_CONST_HT 8'hf0
`define RBT_SCALE_MIN 5'h01
`define RBT_SCALE_MAX 5'h10
`define RBT_FIFO_DEPTH 16
`define RBT_ADDR_W 32
`endif

// ---- rtl/rbt_pkg.sv ----
// types of the raster boolean transfer datapath
`default_nettype none
package rbt_pkg;
  typedef enum logic [1:0] {OP_D = 2'b00, OP_SD = 2'b01, OP_HD = 2'b10, OP_SHD = 2'b11} opnd_type;
  typedef enum logic [1:0] {DK_BANDED = 2'b00, DK_UNBANDED = 2'b01, DK_FRAME = 2'b10} dkind_type;
  typedef struct packed {
    logic [15:0] row;
    logic [31:0] dst_addr;
    logic [31:0] src_addr;
    logic [4:0] sub_y;
    logic [15:0] ht_y;
    logic [7:0] band_num;
  } resume_type;
  typedef struct packed {
    logic [7:0] code;
    opnd_type opnd;
    dkind_type dkind;
    logic expand;
    logic rot180;
    logic [15:0] warp;
    logic [15:0] width;
    logic [15:0] height;
    logic [15:0] dst_y;
    logic [15:0] band_bot;
    logic [15:0] src_warp;
    logic [4:0] xs;
    logic [4:0] ys;
    logic [31:0] ht_addr;
    logic [15:0] ht_w;
    logic [15:0] ht_h;
    resume_type st;
  } order_type;
  typedef struct packed {
    logic [31:0] addr;
    logic data;
  } wr_type;
endpackage
`default_nettype wire

// ---- testbench/rbt_mem_model.sv ----
// bit-addressed shared memory model answering the transfer engine
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// shared bitmap memory
// ****************************************
module rbt_mem_model (
  input wire logic core_clk, // clock
  input wire logic rst, // async reset
  input wire logic stall, // hold write port off
  input wire logic rd_valid, // read request
  output logic rd_ready, // read taken
  input wire logic [31:0] rd_addr, // bit address to read
  output logic rd_resp_valid, // read data strobe
  output logic rd_resp_data, // read data bit
  input wire logic wr_valid, // write request
  output logic wr_ready, // write taken
  input wire logic [31:0] wr_addr, // bit address to write
  input wire logic wr_data // bit to write
);
  logic mem [0:4095];
  logic [31:0] addr_q;
  logic took;
  int seed = 22096;
  int wait_n = 0;
  initial begin
    rd_ready = 1'b0;
    wr_ready = 1'b0;
    rd_resp_valid = 1'b0;
    rd_resp_data = 1'b0;
  end
  always @(posedge core_clk) begin
    took = rd_valid && rd_ready && !rst;
    if (took) addr_q = rd_addr;
    if (wr_valid && wr_ready && !rst) mem[wr_addr[11:0]] = wr_data;
    #1;
    rd_resp_valid = 1'b0;
    // outside a response the data line carries junk that flips every cycle
    rd_resp_data = ~rd_resp_data;
    wr_ready = !stall && !rst && ($random(seed) % 4 != 0);
    if (took) begin
      rd_ready = 1'b0;
      wait_n = 1 + {$random(seed)} % 3;
    end else if (wait_n > 0) begin
      wait_n--;
      if (wait_n == 0) begin
        rd_resp_valid = 1'b1;
        rd_resp_data = mem[addr_q[11:0]];
      end
    end else begin
      rd_ready = !rst && ($random(seed) % 3 != 0);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench of the raster boolean transfer engine
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench top
// ****************************************
module testbench;
  logic core_clk = 1'b0, rst = 1'b1, ord_valid = 1'b0, stall = 1'b0;
  logic ord_ready, rd_valid, rd_ready, rd_resp_valid, rd_resp_data, wr_valid, wr_ready, wr_data, busy, done, fault;
  logic [31:0] rd_addr, wr_addr;
  rbt_pkg::order_type ord = '0;
  rbt_pkg::order_type o;
  rbt_pkg::resume_type resume;
  int fails = 0, n_checks = 0, seed = 22096, nfault = 0;
  logic ref_mem [0:4095];
  logic [32:0] exp_q [$];
  always #12.5 core_clk = ~core_clk;
  raster_boolean_transfer #(.DEPTH(16)) u_dut (.core_clk(core_clk), .rst(rst), .ord_valid(ord_valid),
    .ord_ready(ord_ready), .ord(ord), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr),
    .rd_resp_valid(rd_resp_valid), .rd_resp_data(rd_resp_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy), .done(done), .fault(fault), .resume(resume));
  rbt_mem_model u_mem (.core_clk(core_clk), .rst(rst), .stall(stall), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_addr(rd_addr), .rd_resp_valid(rd_resp_valid), .rd_resp_data(rd_resp_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk) begin
    if (fault === 1'b1) nfault++;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (exp_q.size() == 0) check({31'h0, wr_addr, wr_data}, 64'hffff_ffff_ffff_ffff);
      else check({31'h0, wr_addr, wr_data}, {31'h0, exp_q.pop_front()});
    end
  end
  // reference: walk rows and pixels, predict every write and a possible fault row
  task automatic model(input rbt_pkg::order_type m, output int frow, output rbt_pkg::resume_type er);
    int r, x, pitch, sa, ha;
    logic d, s, h;
    logic [31:0] da;
    frow = -1;
    er = '0;
    pitch = (m.dkind == rbt_pkg::DK_FRAME) ? m.width : m.warp;
    for (r = m.st.row; r < m.height; r++) begin
      if (m.dkind == rbt_pkg::DK_BANDED && m.dst_y + r > m.band_bot) begin
        frow = r;
        er.row = r;
        er.dst_addr = m.st.dst_addr + (r - m.st.row) * pitch;
        er.band_num = m.rot180 ? m.st.band_num - 8'h01 : m.st.band_num + 8'h01;
        return;
      end
      for (x = 0; x < m.width; x++) begin
        da = m.st.dst_addr + (r - m.st.row) * pitch + x;
        if (m.expand) sa = m.st.src_addr + ((r - m.st.row + m.st.sub_y) / m.ys) * m.src_warp + x / m.xs;
        else sa = m.st.src_addr + (r - m.st.row) * m.src_warp + x;
        ha = m.ht_addr + ((m.st.ht_y + r - m.st.row) % m.ht_h) * m.ht_w + x % m.ht_w;
        d = ref_mem[da[11:0]];
        s = m.opnd[0] ? ref_mem[sa % 4096] : 1'b0;
        h = m.opnd[1] ? ref_mem[ha % 4096] : 1'b0;
        d = m.code[{h, s, d}];
        ref_mem[da[11:0]] = d;
        exp_q.push_back({da, d});
      end
    end
  endtask
  task automatic run(input rbt_pkg::order_type m, input string nm);
    int frow, k, f0;
    rbt_pkg::resume_type er;
    model(m, frow, er);
    f0 = nfault;
    ord = m;
    ord_valid = 1'b1;
    k = 0;
    while (ord_ready !== 1'b1 && k < 100) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 100) begin
      fails++;
      final_report();
    end
    // ready was seen settled, so the order is taken at the coming edge
    @(posedge core_clk);
    #1;
    ord_valid = 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 20000);
    if (k >= 20000) begin
      fails++;
      final_report();
    end
    check(exp_q.size(), 0);
    check(nfault - f0, frow >= 0);
    if (frow >= 0) check({resume.row, resume.dst_addr, resume.band_num}, {er.row, er.dst_addr, er.band_num});
    $display("test %s done", nm);
  endtask
  initial begin
    for (int i = 0; i < 4096; i++) begin
      ref_mem[i] = $random(seed);
      u_mem.mem[i] = ref_mem[i];
    end
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check({busy, ord_ready}, 2'b01);
    // every code once, operand mix cycling with the code; unbanded rows run past band_bot unchecked
    for (int c = 0; c < 256; c++) begin
      o = '0;
      o.code = c[7:0];
      o.opnd = rbt_pkg::opnd_type'(c % 4);
      o.dkind = rbt_pkg::DK_UNBANDED;
      o.warp = 16'h0028;
      o.width = 16'(1 + {$random(seed)} % 5);
      o.height = 16'h0002;
      o.src_warp = 16'h0018;
      o.ht_addr = 32'h0000_0c00;
      o.ht_w = 16'h0003;
      o.ht_h = 16'h0002;
      o.st.dst_addr = 32'(100 + 3 * c);
      o.st.src_addr = 32'(2048 + c);
      o.st.ht_y = 16'(c % 2);
      run(o, "code");
    end
    o.dkind = rbt_pkg::DK_FRAME;
    o.width = 16'h0005;
    o.height = 16'h0003;
    run(o, "frame");
    for (int v = 0; v < 2; v++) begin
      o.dkind = rbt_pkg::DK_BANDED;
      o.opnd = rbt_pkg::OP_SD;
      o.code = 8'h66;
      o.rot180 = v[0];
      o.height = 16'h0004;
      o.dst_y = 16'h000a;
      o.band_bot = 16'h000b;
      o.st = '0;
      o.st.dst_addr = 32'h0000_0200;
      o.st.src_addr = 32'h0000_0903;
      o.st.band_num = 8'h05;
      run(o, "band_fault");
      o.st = resume;
      o.band_bot = 16'h0020;
      run(o, "band_resume");
    end
    o = '0;
    o.dkind = rbt_pkg::DK_UNBANDED;
    o.opnd = rbt_pkg::OP_SHD;
    o.code = 8'he2;
    o.expand = 1'b1;
    o.warp = 16'h0028;
    o.src_warp = 16'h0009;
    o.ht_addr = 32'h0000_0c40;
    o.ht_w = 16'h0005;
    o.ht_h = 16'h0003;
    o.st.dst_addr = 32'h0000_0300;
    o.st.src_addr = 32'h0000_0a05;
    for (int v = 0; v < 2; v++) begin
      o.xs = v ? 5'h10 : 5'h03;
      o.ys = v ? 5'h10 : 5'h02;
      o.width = v ? 16'h0012 : 16'h0007;
      o.height = v ? 16'h0002 : 16'h0004;
      run(o, "expand");
    end
    // writes held off: the fifo fills and the engine must wait, not drop pixels
    o.opnd = rbt_pkg::OP_D;
    o.code = 8'h55;
    o.expand = 1'b0;
    o.width = 16'h0014;
    o.height = 16'h0001;
    stall = 1'b1;
    fork
      run(o, "stall");
      begin
        repeat (400) @(posedge core_clk);
        #1;
        check({busy, wr_valid}, 2'b11);
        stall = 1'b0;
      end
    join
    final_report();
  end
endmodule
`default_nettype wire
